/* File: rtl/bsfs_top.sv */
// Buck fault sequencer: start-up, switching sequencing, power-ok and protection.
// Assumes all inputs synchronous to clk_i; registers on classic Wishbone.
// Functional notes
// - frequency select decodes eight codes, open 500 kHz
// - calibration latches selections, switching inhibited
// - soft-start duration from mode setting, four choices
// - after soft-start begins, comparator picks continuous mode
// - off-time ends on set below current limit
// - ramp offset -7 mV at on, 0 off-end
// - skip mode ramp may continue, clamped +3 mV
// - skip mode zero-crossing turnoff, adaptive offset trim
// - enable fall: switches off, discharge on while biased
// - power-ok held low until soft-start completes
// - in-window releases power-ok after 1 ms
// - out-of-window pulls power-ok low after 2 us
// - undervoltage held 1 ms turns drivers off and enters hiccup
// - undervoltage armed 1.5 ms after soft-start
// - hiccup delay then fresh soft-start, repeating
// - hiccup delay seven times (2^n+257)*4 us
// - overvoltage: high-side off, low-side latched on
// - in overvoltage, 1 ms undervoltage latches off
// - backup overvoltage: low-side on, undervoltage latches off
// - supply lockout stops at once, resumes automatically
// - over-temperature stops, resumes automatically when clear
//
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
module bsfs_top
  import bsfs_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Enable, supplies and straps
  input wire logic en_i,
  input wire logic bias_present_i,
  input wire logic [2:0] freq_select_input_i,
  input wire logic [1:0] mode_res_code_i,
  input wire logic mode_cmp_i,
  // Loop and current sense
  input wire logic pwm_set_i,
  input wire logic on_time_done_i,
  input wire logic overcurrent_limit_i,
  input wire logic zero_cross_i,
  input wire logic zc_late_i,
  input wire logic zc_early_i,
  // Window and fault indications
  input wire logic pg_in_win_i,
  input wire logic pg_out_win_i,
  input wire logic undervolt_fault_i,
  input wire logic overvolt_fault_i,
  input wire logic backup_overvolt_sense_i,
  input wire logic supply_lockout_i,
  input wire logic over_temp_i,
  // Power stage
  output logic hs_on_o,
  output logic ls_on_o,
  output logic discharge_o,
  output logic forced_continuous_mode_o,
  output logic [2:0] freq_code_o,
  output logic [4:0] ramp_mv_o,
  output logic [3:0] zc_offset_o,
  // Open-drain power-ok
  output logic power_ok_out_o,
  output logic power_ok_out_oe_o
);
  typedef struct packed {
    bsfs_state_t st;
    logic en;
    logic [11:0] tcnt;
    logic tick;
    logic [TW-1:0] tmr;
    logic [2:0] freq;
    logic [1:0] ss_sel;
    logic forced_continuous_mode;
    logic on_ph;
    logic discontinuous_conduction;
    logic [7:0] rcnt;
    logic [4:0] ramp;
    logic [3:0] zc_off;
    logic hs;
    logic ls;
    logic dis;
    logic pg;
    logic pg_oe;
    logic bk;
    logic soft_en;
    logic zc_en;
    logic ack;
    logic [31:0] dat;
  } bsfs_main_t;

  localparam bsfs_main_t Q_RST = '{
    st: ST_IDLE, soft_en: CTRL_EN_RST, zc_en: CTRL_ZC_RST, pg_oe: 1'b1, default: '0};

  bsfs_main_t q, d;
  logic pg_on_done, pg_off_done, uv_done, uv_armed;
  logic run_ok, bus_req, act;

  // Delay counters on the shared tick
  bsfs_delay #(.W(TW)) u_pg_on (
    .clk_i(clk_i), .rst_i(rst_i), .tick_i(q.tick),
    .run_i(q.st == ST_RUN && pg_in_win_i && !q.pg),
    .limit_i(TW'(PG_ON_US)), .done_o(pg_on_done));
  bsfs_delay #(.W(TW)) u_pg_off (
    .clk_i(clk_i), .rst_i(rst_i), .tick_i(q.tick),
    .run_i(q.pg && pg_out_win_i),
    .limit_i(TW'(PG_OFF_US)), .done_o(pg_off_done));
  bsfs_delay #(.W(TW)) u_uv_arm (
    .clk_i(clk_i), .rst_i(rst_i), .tick_i(q.tick),
    .run_i(q.st == ST_RUN),
    .limit_i(TW'(UV_ARM_US)), .done_o(uv_armed));
  bsfs_delay #(.W(TW)) u_uv (
    .clk_i(clk_i), .rst_i(rst_i), .tick_i(q.tick),
    .run_i(undervolt_fault_i && ((q.st == ST_RUN && uv_armed) || q.st == ST_OVP)),
    .limit_i(TW'(UV_DLY_US)), .done_o(uv_done));

  function automatic logic [31:0] rd_word(input bsfs_main_t s, input logic [7:0] adr);
    rd_word = 32'h0;
    unique case (adr)
      ADR_CTRL: begin
        rd_word[CTRL_EN_BIT] = s.soft_en;
        rd_word[CTRL_ZC_BIT] = s.zc_en;
      end
      ADR_STATUS: begin
        rd_word[2:0] = s.st;
        rd_word[ST_PG_BIT] = s.pg;
        rd_word[ST_FORCED_CONTINUOUS_MODE_BIT] = s.forced_continuous_mode;
        rd_word[ST_DIS_BIT] = s.dis;
        rd_word[ST_BK_BIT] = s.bk;
        rd_word[ST_FREQ_LSB +: 3] = s.freq;
        rd_word[ST_SS_LSB +: 2] = s.ss_sel;
        rd_word[ST_DCM_BIT] = s.discontinuous_conduction;
      end
      ADR_TUNE: begin
        rd_word[4:0] = s.ramp;
        rd_word[TUNE_ZC_LSB +: 4] = s.zc_off;
      end
      default: rd_word = 32'h0;
    endcase
  endfunction

  always_comb begin
    d = q;
    d.en = en_i;
    run_ok = en_i && q.soft_en && !supply_lockout_i && !over_temp_i;
    bus_req = wb_cyc_i && wb_stb_i;
    // Free-running timebase
    d.tick = 1'b0;
    if (q.tcnt == 12'(TICK_CYCLES - 1)) begin
      d.tcnt = 12'h000;
      d.tick = 1'b1;
    end else begin
      d.tcnt = q.tcnt + 12'h001;
    end
    if (q.tick) begin
      d.tmr = q.tmr + 1'b1;
    end
    // Discharge starts only on the enable fall
    if (q.en && !en_i && bias_present_i) begin
      d.dis = 1'b1;
    end else if (en_i || !bias_present_i) begin
      d.dis = 1'b0;
    end
    if (!(en_i && q.soft_en)) begin
      d.st = ST_IDLE;
    end else if ((supply_lockout_i || over_temp_i) && q.st != ST_LATCH) begin
      d.st = ST_IDLE;
    end else begin
      unique case (q.st)
        ST_IDLE: begin
          if (run_ok) begin
            d.st = ST_CAL;
            d.tmr = '0;
          end
        end
        ST_CAL: begin
          if (q.tmr == TW'(CAL_US)) begin
            d.freq = freq_select_input_i;
            d.ss_sel = mode_res_code_i;
            d.st = ST_SS;
            d.tmr = '0;
            d.on_ph = 1'b0;
            d.discontinuous_conduction = 1'b0;
          end
        end
        ST_SS, ST_RUN: begin
          if (overvolt_fault_i || backup_overvolt_sense_i) begin
            d.st = ST_OVP;
            d.bk = backup_overvolt_sense_i && !overvolt_fault_i;
          end else if (q.st == ST_SS && q.tmr == ss_us(q.ss_sel)) begin
            d.st = ST_RUN;
            d.tmr = '0;
          end else if (q.st == ST_RUN && uv_done) begin
            d.st = ST_HIC;
            d.tmr = '0;
          end
        end
        ST_OVP: begin
          if (q.bk ? undervolt_fault_i : uv_done) begin
            d.st = ST_LATCH;
          end
        end
        ST_HIC: begin
          if (q.tmr == hic_dly_us(q.ss_sel)) begin
            d.st = ST_SS;
            d.tmr = '0;
            d.on_ph = 1'b0;
            d.discontinuous_conduction = 1'b0;
          end
        end
        ST_LATCH: d.st = ST_LATCH;
        default: d.st = ST_IDLE;
      endcase
    end
    act = (d.st == ST_SS || d.st == ST_RUN);
    d.forced_continuous_mode = act && mode_cmp_i;
    // Switching cycle
    if (act && q.st == d.st) begin
      if (q.rcnt >= ramp_step(q.freq) - 8'h01) begin
        d.rcnt = 8'h00;
        if ($signed(q.ramp) < $signed(q.discontinuous_conduction ? RAMP_MAX_SKIP_MV : RAMP_MAX_CCM_MV)) begin
          d.ramp = q.ramp + 5'h01;
        end
      end else begin
        d.rcnt = q.rcnt + 8'h01;
      end
      if (q.on_ph) begin
        if (on_time_done_i) begin
          d.on_ph = 1'b0;
          d.discontinuous_conduction = 1'b0;
        end
      end else if (pwm_set_i && !overcurrent_limit_i) begin
        d.on_ph = 1'b1;
        d.ramp = RAMP_START_MV;
        d.rcnt = 8'h00;
      end else if (!q.forced_continuous_mode && zero_cross_i) begin
        d.discontinuous_conduction = 1'b1;
      end
      if (!q.on_ph && !q.forced_continuous_mode && q.zc_en) begin
        if (zc_late_i && q.zc_off != ZC_MAX) begin
          d.zc_off = q.zc_off + 4'h1;
        end else if (zc_early_i && !zc_late_i && q.zc_off != ZC_MIN) begin
          d.zc_off = q.zc_off - 4'h1;
        end
      end
    end
    // Driver outputs follow the next state
    d.hs = act && d.on_ph;
    d.ls = (act && !d.on_ph && !d.discontinuous_conduction) || d.st == ST_OVP;
    // Power-ok
    if (d.st != ST_RUN) begin
      d.pg = 1'b0;
    end else if (pg_off_done) begin
      d.pg = 1'b0;
    end else if (pg_on_done) begin
      d.pg = 1'b1;
    end
    d.pg_oe = !d.pg;
    // Bus slave, one wait state
    d.ack = bus_req && !q.ack;
    if (bus_req && !q.ack) begin
      d.dat = rd_word(q, wb_adr_i);
    end
    if (bus_req && wb_we_i && q.ack && wb_adr_i == ADR_CTRL && wb_sel_i[0]) begin
      d.soft_en = wb_dat_i[CTRL_EN_BIT];
      d.zc_en = wb_dat_i[CTRL_ZC_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= Q_RST;
    end else begin
      q <= d;
    end
  end

  assign wb_dat_o = q.dat;
  assign wb_ack_o = q.ack;
  assign hs_on_o = q.hs;
  assign ls_on_o = q.ls;
  assign discharge_o = q.dis;
  assign forced_continuous_mode_o = q.forced_continuous_mode;
  assign freq_code_o = q.freq;
  assign ramp_mv_o = q.ramp;
  assign zc_offset_o = q.zc_off;
  assign power_ok_out_o = q.pg;
  assign power_ok_out_oe_o = q.pg_oe;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_en_fall;
    q.en && !en_i && bias_present_i;
  endsequence
  sequence s_off_end;
    (q.st == ST_RUN) && !q.on_ph && pwm_set_i;
  endsequence

  property p_cal_quiet;
    q.st == ST_CAL |-> !hs_on_o && !ls_on_o;
  endproperty
  a_cal_quiet: assert property (p_cal_quiet) else $error("switching during calibration");
  property p_off_end;
    $rose(hs_on_o) |-> $past(pwm_set_i) && !$past(overcurrent_limit_i);
  endproperty
  a_off_end: assert property (p_off_end) else $error("off-time ended without valid set");
  property p_ocl_hold;
    s_off_end ##0 overcurrent_limit_i ##0 (d.st == ST_RUN) |=> !hs_on_o;
  endproperty
  a_ocl_hold: assert property (p_ocl_hold) else $error("off-time ended over limit");
  property p_ramp_start;
    $rose(hs_on_o) |-> ramp_mv_o == RAMP_START_MV;
  endproperty
  a_ramp_start: assert property (p_ramp_start) else $error("ramp not at start value");
  property p_ramp_clamp;
    $signed(ramp_mv_o) <= $signed(RAMP_MAX_SKIP_MV);
  endproperty
  a_ramp_clamp: assert property (p_ramp_clamp) else $error("ramp above clamp");
  property p_discharge;
    s_en_fall |=> discharge_o && !hs_on_o && !ls_on_o;
  endproperty
  a_discharge: assert property (p_discharge) else $error("no discharge on enable fall");
  property p_pg_gate;
    q.st != ST_RUN |-> !power_ok_out_o && power_ok_out_oe_o;
  endproperty
  a_pg_gate: assert property (p_pg_gate) else $error("power-ok high before run");
  property p_pg_rise;
    $rose(power_ok_out_o) |-> $past(pg_on_done);
  endproperty
  a_pg_rise: assert property (p_pg_rise) else $error("power-ok rose without delay");
  property p_ovp_drive;
    q.st == ST_OVP |-> ls_on_o && !hs_on_o;
  endproperty
  a_ovp_drive: assert property (p_ovp_drive) else $error("overvoltage drive wrong");
  property p_lockout;
    supply_lockout_i && q.st != ST_LATCH |=> q.st == ST_IDLE && !hs_on_o && !ls_on_o;
  endproperty
  a_lockout: assert property (p_lockout) else $error("lockout did not stop");
endmodule
`default_nettype wire

/* File: rtl/bsfs_pkg.sv */
// Constants, state codes and timing helpers for the buck fault sequencer.
// Assumes a 50 MHz clock; all delays are counted in 1 us timebase ticks.
package bsfs_pkg;
  localparam int CLK_NS = 20;
  localparam int CLK_KHZ = 1000000 / CLK_NS;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int TW = 17;

  // Times in microseconds (one tick each)
  localparam int CAL_US = 250;
  localparam int PG_ON_US = 1000;
  localparam int PG_OFF_US = 2;
  localparam int UV_DLY_US = 1000;
  localparam int UV_ARM_US = 1500;
  localparam int SS0_US = 700;
  localparam int SS1_US = 1400;
  localparam int SS2_US = 2800;
  localparam int SS3_US = 5600;
  localparam int HIC_BASE = 257;
  localparam int HIC_STEP_US = 4;
  localparam int HIC_MULT = 7;
  localparam int HIC_N0 = 8;

  // Ramp offset in mV, two's complement
  localparam logic [4:0] RAMP_START_MV = 5'h19;
  localparam logic [4:0] RAMP_MAX_SKIP_MV = 5'h03;
  localparam logic [4:0] RAMP_MAX_CCM_MV = 5'h00;
  localparam int RAMP_STEPS = 7;

  localparam logic [3:0] ZC_MAX = 4'h7;
  localparam logic [3:0] ZC_MIN = 4'h8;
  localparam logic [2:0] FREQ_OPEN = 3'h3;

  // Register byte addresses and fields
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_TUNE = 8'h08;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_ZC_BIT = 1;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic CTRL_ZC_RST = 1'b1;
  localparam int ST_PG_BIT = 3;
  localparam int ST_FORCED_CONTINUOUS_MODE_BIT = 4;
  localparam int ST_DIS_BIT = 5;
  localparam int ST_BK_BIT = 6;
  localparam int ST_FREQ_LSB = 7;
  localparam int ST_SS_LSB = 10;
  localparam int ST_DCM_BIT = 12;
  localparam int TUNE_ZC_LSB = 8;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CAL = 3'b001,
    ST_SS = 3'b010,
    ST_RUN = 3'b011,
    ST_OVP = 3'b100,
    ST_HIC = 3'b101,
    ST_LATCH = 3'b110
  } bsfs_state_t;

  function automatic int freq_khz(input logic [2:0] code);
    unique case (code)
      3'h0: freq_khz = 250;
      3'h1: freq_khz = 300;
      3'h2: freq_khz = 400;
      3'h3: freq_khz = 500;
      3'h4: freq_khz = 600;
      3'h5: freq_khz = 750;
      3'h6: freq_khz = 850;
      default: freq_khz = 970;
    endcase
  endfunction

  function automatic logic [7:0] ramp_step(input logic [2:0] code);
    ramp_step = 8'((CLK_KHZ / freq_khz(code)) / RAMP_STEPS);
  endfunction

  function automatic logic [TW-1:0] ss_us(input logic [1:0] sel);
    unique case (sel)
      2'h0: ss_us = TW'(SS0_US);
      2'h1: ss_us = TW'(SS1_US);
      2'h2: ss_us = TW'(SS2_US);
      default: ss_us = TW'(SS3_US);
    endcase
  endfunction

  function automatic logic [TW-1:0] hic_dly_us(input logic [1:0] sel);
    hic_dly_us = TW'(HIC_MULT * ((1 << (HIC_N0 + int'(sel))) + HIC_BASE) * HIC_STEP_US);
  endfunction
endpackage

/* File: rtl/bsfs_delay.sv */
// Tick-counted delay: done rises once run has held for limit ticks.
// Assumes tick_i is a one-cycle pulse from the shared timebase.
`timescale 1ns/1ns
`default_nettype none
module bsfs_delay
  import bsfs_pkg::*;
#(
  parameter int W = TW
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic tick_i,
  input wire logic run_i,
  input wire logic [W-1:0] limit_i,
  // Result
  output logic done_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic done;
  } bsfs_dly_t;

  bsfs_dly_t q, d;

  always_comb begin
    d = q;
    if (!run_i) begin
      d = '0;
    end else if (q.cnt == limit_i) begin
      d.done = 1'b1;
    end else if (tick_i) begin
      d.cnt = q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done_o = q.done;

  property p_dly_clear;
    @(posedge clk_i) disable iff (rst_i) !run_i |=> !done_o;
  endproperty
  a_dly_clear: assert property (p_dly_clear) else $error("delay done without run");
endmodule
`default_nettype wire

/* File: testbench/bsfs_stage_model.sv */
// Power stage model: ends the on phase after a few cycles, the off phase only while auto is set.
// Assumes sequencer switch commands; power-ok line has a pull-up.
`timescale 1ns/1ns
`default_nettype none
module bsfs_stage_model (
  // Clock and commands
  input wire logic clk_i,
  input wire logic auto_i,
  input wire logic hs_on_i,
  input wire logic ls_on_i,
  input wire logic pg_oe_i,
  // Loop feedback
  output logic set_o,
  output logic on_done_o,
  output wire logic pg_line_o
);
  logic [3:0] cnt_q = 4'h0;
  logic hs_q = 1'b0;
  // Pull-up wins while nothing sinks the line
  assign pg_line_o = pg_oe_i ? 1'b0 : 1'b1;
  assign set_o = auto_i && ls_on_i && cnt_q == 4'h8;
  // On-time always ends; auto gates only the set
  assign on_done_o = hs_on_i && cnt_q == 4'h4;
  always_ff @(posedge clk_i) begin
    hs_q <= hs_on_i;
    if (hs_q != hs_on_i) begin
      cnt_q <= 4'h0;
    end else if (cnt_q != 4'hF) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/bsfs_top_test.sv */
// Self-checking bench for the buck fault sequencer.
// Assumes a 1-cycle tick so every delay counts clock cycles.
`timescale 1ns/1ns
`default_nettype none
module bsfs_top_test;
  import bsfs_pkg::*;
  logic clk_i = 0;
  logic rst_i = 1;
  logic cyc = 0, stb = 0, we = 0, ack;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic en = 0, bias = 1, mcmp = 0, mset = 0, oc = 0, auto = 1;
  logic [2:0] fsel = 3'h3, fcode;
  logic [1:0] mres = 2'h0;
  logic inw = 0, outw = 0, uv = 0, ov = 0, lock = 0, hot = 0, zc = 0, bkov = 0;
  logic hs, ls, dis, forced_continuous_mode, pg, pgoe, aset, adone, pgl;
  logic [4:0] ramp;
  logic [3:0] zoff;
  int errors = 0;
  int cmp_count = 0;
  bsfs_top #(.TICK_CYCLES(1)) uut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .en_i(en), .bias_present_i(bias), .freq_select_input_i(fsel),
    .mode_res_code_i(mres), .mode_cmp_i(mcmp), .pwm_set_i(aset | mset),
    .on_time_done_i(adone), .overcurrent_limit_i(oc), .zero_cross_i(zc),
    .zc_late_i(zc), .zc_early_i(1'b0), .pg_in_win_i(inw),
    .pg_out_win_i(outw), .undervolt_fault_i(uv), .overvolt_fault_i(ov),
    .backup_overvolt_sense_i(bkov), .supply_lockout_i(lock),
    .over_temp_i(hot), .hs_on_o(hs), .ls_on_o(ls), .discharge_o(dis),
    .forced_continuous_mode_o(forced_continuous_mode), .freq_code_o(fcode),
    .ramp_mv_o(ramp), .zc_offset_o(zoff), .power_ok_out_o(pg),
    .power_ok_out_oe_o(pgoe));
  bsfs_stage_model stage (.clk_i(clk_i), .auto_i(auto), .hs_on_i(hs),
    .ls_on_i(ls), .pg_oe_i(pgoe), .set_o(aset), .on_done_o(adone),
    .pg_line_o(pgl));
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  task automatic tally_and_finish;
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // One classic cycle; entered and left just after a rising edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 20) begin
      chk("bus ack", 1'b1, ack);
    end
    tk(1);
  endtask
  task automatic wait_st(input logic [2:0] s, input int m, output int n);
    logic [31:0] q;
    n = 0;
    q = 32'hFFFFFFFF;
    while (q[2:0] !== s && n < m) begin
      wb(1'b0, ADR_STATUS, 32'h0, q);
      n++;
    end
    chk("state", s, q[2:0]);
  endtask
  task automatic t_reset;
    logic [31:0] q;
    chk("oe after reset", 1'b1, pgoe);
    chk("hs after reset", 1'b0, hs);
    chk("zc reset", 4'h0, zoff);
    wb(1'b0, ADR_CTRL, 32'h0, q);
    chk("ctrl reset", 32'h3, q);
    wb(1'b1, 8'h0C, 32'hFFFFFFFF, q);
    wb(1'b0, 8'h0C, 32'h0, q);
    chk("unmapped", 32'h0, q);
  endtask
  task automatic t_start;
    logic [31:0] q;
    int n;
    fsel <= 3'h5;
    mcmp <= 1'b1;
    inw <= 1'b1;
    en <= 1'b1;
    tk(20);
    chk("cal ls", 1'b0, ls);
    wait_st(ST_SS, 100, n);
    fsel <= 3'h2;
    wb(1'b0, ADR_STATUS, 32'h0, q);
    chk("freq", 3'h5, q[9:7]);
    chk("forced_continuous_mode", 1'b1, forced_continuous_mode);
    chk("pg in ss", 1'b1, pgoe);
    wait_st(ST_RUN, 300, n);
    chk("ss len", 1'b1, n * 3 > 680 && n * 3 < 712);
    n = 0;
    while (pg !== 1'b1 && n < 2000) begin
      tk(1);
      n++;
    end
    chk("pg delay", 1'b1, n > 985 && n < 1005);
    chk("pg line", 1'b1, pgl);
  endtask
  task automatic t_off;
    auto <= 1'b0;
    tk(100);
    chk("ramp ccm", 5'h00, ramp);
    oc <= 1'b1;
    mset <= 1'b1;
    tk(5);
    chk("hs oc", 1'b0, hs);
    oc <= 1'b0;
    tk(2);
    mset <= 1'b0;
    chk("hs set", 1'b1, hs);
    chk("ls set", 1'b0, ls);
    chk("ramp on", 5'h19, ramp);
    auto <= 1'b1;
    tk(20);
  endtask
  task automatic t_skip;
    auto <= 1'b0;
    mcmp <= 1'b0;
    zc <= 1'b1;
    tk(110);
    chk("skip ls", 1'b0, ls);
    chk("zc trim", ZC_MAX, zoff);
    chk("ramp skip", RAMP_MAX_SKIP_MV, ramp);
    zc <= 1'b0;
    mcmp <= 1'b1;
    mset <= 1'b1;
    tk(1);
    mset <= 1'b0;
    auto <= 1'b1;
    tk(20);
  endtask
  task automatic t_bk;
    logic [31:0] q;
    int n;
    wait_st(ST_SS, 120, n);
    bkov <= 1'b1;
    tk(3);
    chk("bk hs ls", 2'b01, {hs, ls});
    bkov <= 1'b0;
    wb(1'b0, ADR_STATUS, 32'h0, q);
    chk("bk source", 1'b1, q[ST_BK_BIT]);
    uv <= 1'b1;
    wait_st(ST_LATCH, 3, n);
    chk("bk latch hs ls", 2'b00, {hs, ls});
    uv <= 1'b0;
  endtask
  task automatic t_pgdrop;
    int n;
    outw <= 1'b1;
    inw <= 1'b0;
    n = 0;
    while (pg !== 1'b0 && n < 20) begin
      tk(1);
      n++;
    end
    chk("pg drop", 1'b1, n >= 2 && n <= 5);
    outw <= 1'b0;
    inw <= 1'b1;
  endtask
  task automatic t_uv;
    int n;
    tk(600);
    uv <= 1'b1;
    tk(500);
    uv <= 1'b0;
    wait_st(ST_RUN, 1, n);
    uv <= 1'b1;
    wait_st(ST_HIC, 400, n);
    chk("uv len", 1'b1, n * 3 > 990 && n * 3 < 1010);
    chk("hic hs ls", 2'b00, {hs, ls});
    uv <= 1'b0;
    wait_st(ST_SS, 6000, n);
    chk("hic len", 1'b1, n * 3 > 14355 && n * 3 < 14372);
    wait_st(ST_RUN, 300, n);
    uv <= 1'b1;
    tk(1200);
    uv <= 1'b0;
    wait_st(ST_RUN, 1, n);
  endtask
  task automatic t_ovp;
    int n;
    ov <= 1'b1;
    tk(3);
    ov <= 1'b0;
    chk("ovp hs ls", 2'b01, {hs, ls});
    tk(20);
    chk("ovp held", 2'b01, {hs, ls});
    uv <= 1'b1;
    wait_st(ST_LATCH, 400, n);
    chk("ovp uv len", 1'b1, n * 3 > 990 && n * 3 < 1010);
    chk("latch hs ls", 2'b00, {hs, ls});
    uv <= 1'b0;
    en <= 1'b0;
    tk(3);
    chk("discharge", 1'b1, dis);
    chk("dis hs ls", 2'b00, {hs, ls});
    bias <= 1'b0;
    tk(3);
    chk("no bias", 1'b0, dis);
    bias <= 1'b1;
  endtask
  task automatic t_lock;
    int n;
    for (int i = 0; i < 2; i++) begin
      en <= 1'b1;
      wait_st(ST_SS, 120, n);
      lock <= (i == 0);
      hot <= (i == 1);
      tk(3);
      chk("shut hs ls", 2'b00, {hs, ls});
      wait_st(ST_IDLE, 5, n);
      lock <= 1'b0;
      hot <= 1'b0;
      wait_st(ST_CAL, 5, n);
    end
  endtask
  initial begin
    tk(10);
    rst_i <= 1'b0;
    tk(1);
    t_reset();
    t_start();
    t_off();
    t_skip();
    t_pgdrop();
    t_uv();
    t_ovp();
    t_lock();
    t_bk();
    tally_and_finish();
  end
  initial begin
    tk(80000);
    errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
